/* rtl/mmr_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module mmr_capture (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [15:0] i_par_data,
	input wire logic [3:0] i_strobe,
	mmr_link_if.capture lk
);
	logic [3:0] strobe_d_reg;
	logic [7:0] buf_reg [3];
	logic [3:0] rise;

	assign rise = i_strobe & ~strobe_d_reg;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			strobe_d_reg <= 4'h0;
		end else begin
			strobe_d_reg <= i_strobe;
		end
	end

	// ----------------------------------------
	// decade buffers
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int n = 0; n < 3; n++) begin
				buf_reg[n] <= 8'h00;
			end
		end else begin
			for (int n = 0; n < 3; n++) begin
				unique case (lk.coding_mode)
					mmr_pkg::CODE_BCD, mmr_pkg::CODE_BIN: begin
						// single strobe loads all three nibbles, i_par_data[11:0], at once
						if (lk.strobe_scheme == mmr_pkg::STRB_SINGLE) begin
							if (rise[0]) buf_reg[n] <= {4'h0, i_par_data[4*n +: 4]};
						end else if (rise[n]) begin
							buf_reg[n] <= {4'h0, i_par_data[3:0]};
						end
					end
					mmr_pkg::CODE_TEXT_CHAR: begin
						if (rise[n]) buf_reg[n] <= {1'b0, i_par_data[6:0]};
					end
					mmr_pkg::CODE_RAW_OCTET: begin
						if (rise[n]) buf_reg[n] <= i_par_data[7:0];
					end
				endcase
			end
		end
	end

	assign lk.latched = buf_reg;
endmodule
`default_nettype wire

/* rtl/mmr_gap_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module mmr_gap_timer #(
	parameter int SECOND_CYCLES = mmr_pkg::SECOND_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_frame_rx,
	mmr_link_if.gap lk
);
	logic [31:0] cyc_reg;
	logic [6:0] sec_reg;
	logic expired_reg;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cyc_reg <= 32'h0;
			sec_reg <= 7'h0;
			expired_reg <= 1'b0;
		end else if (i_frame_rx || lk.gap_restart || lk.gap_timeout == 7'h0) begin
			// zero timeout disables supervision entirely
			cyc_reg <= 32'h0;
			sec_reg <= 7'h0;
			expired_reg <= 1'b0;
		end else if (!expired_reg) begin
			if (cyc_reg == 32'(SECOND_CYCLES - 1)) begin
				cyc_reg <= 32'h0;
				sec_reg <= sec_reg + 7'h1;
				if (sec_reg + 7'h1 == lk.gap_timeout) expired_reg <= 1'b1;
			end else begin
				cyc_reg <= cyc_reg + 32'h1;
			end
		end
	end

	assign lk.gap_expired = expired_reg;
endmodule
`default_nettype wire

/* rtl/mmr_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mmr_link_if;
	logic [1:0] coding_mode;
	logic [1:0] strobe_scheme;
	logic [7:0] latched [3];
	logic [6:0] gap_timeout;
	logic gap_restart;
	logic gap_expired;
	modport owner (output coding_mode, output strobe_scheme, input latched,
		output gap_timeout, output gap_restart, input gap_expired);
	modport capture (input coding_mode, input strobe_scheme, output latched);
	modport gap (input gap_timeout, input gap_restart, output gap_expired);
endinterface
`default_nettype wire

/* rtl/mmr_pkg.sv */
package mmr_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [15:0] OFS_PATTERN2 = 16'h0011;
	localparam logic [15:0] OFS_PATTERN3 = 16'h0012;
	localparam logic [15:0] OFS_PATTERN4 = 16'h0013;
	localparam logic [15:0] OFS_NODE_ADDR = 16'h0020;
	localparam logic [15:0] OFS_SIGNATURE = 16'h0021;
	localparam logic [15:0] OFS_RATE = 16'h0022;
	localparam logic [15:0] OFS_PERMIT = 16'h0023;
	localparam logic [15:0] OFS_REPLY_DELAY = 16'h0025;
	localparam logic [15:0] OFS_GAP_TIMEOUT = 16'h0027;
	localparam logic [15:0] OFS_LUMINANCE = 16'h002d;
	localparam logic [15:0] OFS_ENTRY_STYLE = 16'h002f;
	localparam logic [15:0] OFS_LATCH0 = 16'h0040;
	localparam logic [15:0] OFS_LATCH2 = 16'h0042;
	// ----------------------------------------
	// ranges and identity
	// ----------------------------------------
	// arbitrary value, not tied to any part
	localparam logic [15:0] SIGNATURE_CODE = 16'h5a01;
	localparam logic [15:0] RATE_MAX = 16'h0007;
	localparam logic [15:0] DELAY_MAX = 16'h0005;
	localparam logic [15:0] TIMEOUT_MAX = 16'h0063;
	localparam logic [15:0] LUM_MIN = 16'h0001;
	localparam logic [15:0] LUM_MAX = 16'h0008;
	localparam logic [15:0] BYTE_MAX = 16'h00ff;
	localparam logic [15:0] BIT_MAX = 16'h0001;
	// ----------------------------------------
	// exception codes
	// ----------------------------------------
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;
	localparam logic [7:0] EXC_NO_PERMIT = 8'h08;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_NODE_ADDR = 8'h01;
	localparam logic [2:0] RST_RATE = 3'h3;
	localparam logic RST_PERMIT = 1'b1;
	localparam logic [2:0] RST_DELAY = 3'h0;
	localparam logic [6:0] RST_TIMEOUT = 7'h00;
	localparam logic [3:0] RST_LUM = 4'h8;
	localparam logic RST_STYLE = 1'b0;
	localparam logic [7:0] RST_PATTERN = 8'h00;
	// ----------------------------------------
	// coding modes, strobe schemes
	// ----------------------------------------
	localparam logic [1:0] CODE_BCD = 2'h0;
	localparam logic [1:0] CODE_BIN = 2'h1;
	localparam logic [1:0] CODE_RAW_OCTET = 2'h2;
	localparam logic [1:0] CODE_TEXT_CHAR = 2'h3;
	localparam logic [1:0] STRB_SINGLE = 2'h0;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int SECOND_CYCLES = CLK_HZ;
	localparam int RATE_BPS [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
	localparam logic [7:0] DELAY_CHARS [6] = '{8'h00, 8'h0a, 8'h14, 8'h32, 8'h64, 8'hc8};
	localparam int DIV_W = 17;
endpackage

/* rtl/mmr_regbank.sv */
`timescale 1ns/1ps
`default_nettype none
module mmr_regbank #(
	parameter int SECOND_CYCLES = mmr_pkg::SECOND_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic i_req_broadcast,
	input wire logic [15:0] i_req_addr,
	input wire logic [15:0] i_req_wdata,
	input wire logic i_frame_rx,
	input wire logic [1:0] i_coding_mode,
	input wire logic [1:0] i_strobe_scheme,
	input wire logic [15:0] i_par_data,
	input wire logic [3:0] i_strobe,
	output logic o_rsp_valid,
	output logic o_rsp_send,
	output logic [7:0] o_rsp_exc,
	output logic [15:0] o_rsp_rdata,
	output logic [7:0] o_rsp_node_addr,
	output logic [16:0] o_rsp_baud_div,
	output logic [7:0] o_node_addr,
	output logic [16:0] o_baud_div,
	output logic [7:0] o_reply_delay_chars,
	output logic o_gap_expired,
	output logic [3:0] o_luminance,
	output logic o_edit_slide,
	output logic o_write_permit,
	output logic [7:0] o_pattern2,
	output logic [7:0] o_pattern3,
	output logic [7:0] o_pattern4
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [16:0] baud_divisor(input logic [2:0] code);
		baud_divisor = 17'(mmr_pkg::CLK_HZ / mmr_pkg::RATE_BPS[code]);
	endfunction

	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] node_addr_reg;
	logic [2:0] rate_reg;
	logic [16:0] baud_div_reg;
	logic permit_reg;
	logic [2:0] delay_reg;
	logic [7:0] delay_chars_reg;
	logic [6:0] timeout_reg;
	logic [3:0] lum_reg;
	logic style_reg;
	logic [7:0] pattern_reg [3];
	logic gap_restart_reg;
	logic gap_expired_reg;

	logic rsp_valid_reg;
	logic rsp_send_reg;
	logic [7:0] rsp_exc_reg;
	logic [15:0] rsp_rdata_reg;
	logic [7:0] rsp_node_addr_reg;
	logic [16:0] rsp_baud_div_reg;

	mmr_link_if lk ();

	assign lk.coding_mode = i_coding_mode;
	assign lk.strobe_scheme = i_strobe_scheme;
	assign lk.gap_timeout = timeout_reg;
	assign lk.gap_restart = gap_restart_reg;

	mmr_capture u_capture (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_par_data(i_par_data),
		.i_strobe(i_strobe),
		.lk(lk.capture)
	);

	mmr_gap_timer #(
		.SECOND_CYCLES(SECOND_CYCLES)
	) u_gap (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_frame_rx(i_frame_rx),
		.lk(lk.gap)
	);

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	logic known;
	logic read_only;
	logic value_ok;
	logic [7:0] exc;
	logic [15:0] rdata;
	logic wr_ok;

	always_comb begin
		known = 1'b1;
		read_only = 1'b0;
		value_ok = 1'b1;
		rdata = 16'h0000;
		unique case (i_req_addr)
			mmr_pkg::OFS_PATTERN2, mmr_pkg::OFS_PATTERN3, mmr_pkg::OFS_PATTERN4: begin
				rdata = {8'h00, pattern_reg[2'(i_req_addr - mmr_pkg::OFS_PATTERN2)]};
				value_ok = in_range(i_req_wdata, 16'h0000, mmr_pkg::BYTE_MAX);
			end
			mmr_pkg::OFS_NODE_ADDR: begin
				rdata = {8'h00, node_addr_reg};
				value_ok = in_range(i_req_wdata, 16'h0001, mmr_pkg::BYTE_MAX);
			end
			mmr_pkg::OFS_SIGNATURE: begin
				rdata = mmr_pkg::SIGNATURE_CODE;
				read_only = 1'b1;
			end
			mmr_pkg::OFS_RATE: begin
				rdata = {13'h0000, rate_reg};
				value_ok = in_range(i_req_wdata, 16'h0000, mmr_pkg::RATE_MAX);
			end
			mmr_pkg::OFS_PERMIT: begin
				rdata = {15'h0000, permit_reg};
				value_ok = in_range(i_req_wdata, 16'h0000, mmr_pkg::BIT_MAX);
			end
			mmr_pkg::OFS_REPLY_DELAY: begin
				rdata = {13'h0000, delay_reg};
				value_ok = in_range(i_req_wdata, 16'h0000, mmr_pkg::DELAY_MAX);
			end
			mmr_pkg::OFS_GAP_TIMEOUT: begin
				rdata = {9'h000, timeout_reg};
				value_ok = in_range(i_req_wdata, 16'h0000, mmr_pkg::TIMEOUT_MAX);
			end
			mmr_pkg::OFS_LUMINANCE: begin
				rdata = {12'h000, lum_reg};
				value_ok = in_range(i_req_wdata, mmr_pkg::LUM_MIN, mmr_pkg::LUM_MAX);
			end
			mmr_pkg::OFS_ENTRY_STYLE: begin
				rdata = {15'h0000, style_reg};
				value_ok = in_range(i_req_wdata, 16'h0000, mmr_pkg::BIT_MAX);
			end
			mmr_pkg::OFS_LATCH0, mmr_pkg::OFS_LATCH0 + 16'h0001, mmr_pkg::OFS_LATCH2: begin
				rdata = {8'h00, lk.latched[2'(i_req_addr - mmr_pkg::OFS_LATCH0)]};
				read_only = 1'b1;
			end
			default: begin
				known = 1'b0;
			end
		endcase
	end

	// unknown address first, then permission, then read-only address, then value
	always_comb begin
		exc = mmr_pkg::EXC_NONE;
		if (!known) begin
			exc = mmr_pkg::EXC_ADDR;
		end else if (i_req_write && !permit_reg) begin
			exc = mmr_pkg::EXC_NO_PERMIT;
		end else if (i_req_write && read_only) begin
			exc = mmr_pkg::EXC_ADDR;
		end else if (i_req_write && !value_ok) begin
			exc = mmr_pkg::EXC_VALUE;
		end
	end

	// broadcasts still write; only the reply is suppressed
	assign wr_ok = i_req_valid && i_req_write && (exc == mmr_pkg::EXC_NONE);

	// ----------------------------------------
	// settings
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			node_addr_reg <= mmr_pkg::RST_NODE_ADDR;
		end else if (wr_ok && i_req_addr == mmr_pkg::OFS_NODE_ADDR) begin
			node_addr_reg <= i_req_wdata[7:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rate_reg <= mmr_pkg::RST_RATE;
			baud_div_reg <= baud_divisor(mmr_pkg::RST_RATE);
		end else if (wr_ok && i_req_addr == mmr_pkg::OFS_RATE) begin
			rate_reg <= i_req_wdata[2:0];
			baud_div_reg <= baud_divisor(i_req_wdata[2:0]);
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			permit_reg <= mmr_pkg::RST_PERMIT;
		end else if (wr_ok && i_req_addr == mmr_pkg::OFS_PERMIT) begin
			permit_reg <= i_req_wdata[0];
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			delay_reg <= mmr_pkg::RST_DELAY;
			delay_chars_reg <= mmr_pkg::DELAY_CHARS[mmr_pkg::RST_DELAY];
		end else if (wr_ok && i_req_addr == mmr_pkg::OFS_REPLY_DELAY) begin
			delay_reg <= i_req_wdata[2:0];
			delay_chars_reg <= mmr_pkg::DELAY_CHARS[i_req_wdata[2:0]];
		end
	end

	// a new timeout restarts supervision so it acts at once
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			timeout_reg <= mmr_pkg::RST_TIMEOUT;
			gap_restart_reg <= 1'b0;
		end else begin
			gap_restart_reg <= wr_ok && i_req_addr == mmr_pkg::OFS_GAP_TIMEOUT;
			if (wr_ok && i_req_addr == mmr_pkg::OFS_GAP_TIMEOUT) begin
				timeout_reg <= i_req_wdata[6:0];
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			lum_reg <= mmr_pkg::RST_LUM;
		end else if (wr_ok && i_req_addr == mmr_pkg::OFS_LUMINANCE) begin
			lum_reg <= i_req_wdata[3:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			style_reg <= mmr_pkg::RST_STYLE;
		end else if (wr_ok && i_req_addr == mmr_pkg::OFS_ENTRY_STYLE) begin
			style_reg <= i_req_wdata[0];
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int n = 0; n < 3; n++) begin
				pattern_reg[n] <= mmr_pkg::RST_PATTERN;
			end
		end else if (wr_ok && i_req_addr >= mmr_pkg::OFS_PATTERN2 && i_req_addr <= mmr_pkg::OFS_PATTERN4) begin
			pattern_reg[2'(i_req_addr - mmr_pkg::OFS_PATTERN2)] <= i_req_wdata[7:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			gap_expired_reg <= 1'b0;
		end else begin
			// one cycle behind the timer, keeps the output a local flop
			gap_expired_reg <= lk.gap_expired;
		end
	end

	// ----------------------------------------
	// response
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rsp_valid_reg <= 1'b0;
			rsp_send_reg <= 1'b0;
			rsp_exc_reg <= mmr_pkg::EXC_NONE;
			rsp_rdata_reg <= 16'h0000;
			rsp_node_addr_reg <= mmr_pkg::RST_NODE_ADDR;
			rsp_baud_div_reg <= baud_divisor(mmr_pkg::RST_RATE);
		end else begin
			rsp_valid_reg <= i_req_valid;
			if (i_req_valid) begin
				rsp_send_reg <= !i_req_broadcast;
				rsp_exc_reg <= exc;
				rsp_rdata_reg <= (i_req_write || exc != mmr_pkg::EXC_NONE) ? 16'h0000 : rdata;
				// address sampled before the write lands
				rsp_node_addr_reg <= node_addr_reg;
				if (wr_ok && i_req_addr == mmr_pkg::OFS_RATE) begin
					rsp_baud_div_reg <= baud_divisor(i_req_wdata[2:0]);
				end else begin
					rsp_baud_div_reg <= baud_div_reg;
				end
			end else begin
				rsp_send_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_rsp_valid = rsp_valid_reg;
	assign o_rsp_send = rsp_send_reg;
	assign o_rsp_exc = rsp_exc_reg;
	assign o_rsp_rdata = rsp_rdata_reg;
	assign o_rsp_node_addr = rsp_node_addr_reg;
	assign o_rsp_baud_div = rsp_baud_div_reg;
	assign o_node_addr = node_addr_reg;
	assign o_baud_div = baud_div_reg;
	assign o_reply_delay_chars = delay_chars_reg;
	assign o_gap_expired = gap_expired_reg;
	assign o_luminance = lum_reg;
	assign o_edit_slide = style_reg;
	assign o_write_permit = permit_reg;
	assign o_pattern2 = pattern_reg[0];
	assign o_pattern3 = pattern_reg[1];
	assign o_pattern4 = pattern_reg[2];
endmodule
`default_nettype wire

/* test/meter_modbus_register_map_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module meter_modbus_register_map_tb;
	localparam int SEC = 10;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_frame_rx = 1'b0;
	logic [1:0] i_coding_mode = 2'h0;
	logic [1:0] i_strobe_scheme = 2'h0;
	logic [15:0] i_par_data = 16'h0000;
	logic [3:0] i_strobe = 4'h0;
	logic i_req_valid, i_req_write, i_req_broadcast, o_rsp_valid, o_rsp_send, o_gap_expired;
	logic o_edit_slide, o_write_permit;
	logic [15:0] i_req_addr, i_req_wdata, o_rsp_rdata;
	logic [7:0] o_rsp_exc, o_rsp_node_addr, o_node_addr, o_reply_delay_chars, o_pattern2, o_pattern3, o_pattern4;
	logic [16:0] o_rsp_baud_div, o_baud_div;
	logic [3:0] o_luminance;
	logic [24:0] exp_q [$];
	int num_errors = 0;
	int tests_run = 0;
	int bps [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
	logic [7:0] dly [6] = '{8'h00, 8'h0a, 8'h14, 8'h32, 8'h64, 8'hc8};
	logic [31:0] rst_tab [14] = '{32'h0011_0000, 32'h0012_0000, 32'h0013_0000, 32'h0020_0001, 32'h0021_5a01,
		32'h0022_0003, 32'h0023_0001, 32'h0025_0000, 32'h0027_0000, 32'h002d_0008, 32'h002f_0000,
		32'h0040_0000, 32'h0041_0000, 32'h0042_0000};
	logic [47:0] rng [9] = '{48'h0011_0000_00ff, 48'h0012_0000_00ff, 48'h0013_0000_00ff, 48'h0020_0001_00ff,
		48'h0022_0000_0007, 48'h0025_0000_0005, 48'h0027_0000_0063, 48'h002d_0001_0008, 48'h002f_0000_0001};
	always #5 i_clk = ~i_clk;
	mmr_regbank #(.SECOND_CYCLES(SEC)) u_mmr_regbank (.i_clk(i_clk), .i_reset(i_reset),
		.i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_broadcast(i_req_broadcast),
		.i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .i_frame_rx(i_frame_rx),
		.i_coding_mode(i_coding_mode), .i_strobe_scheme(i_strobe_scheme), .i_par_data(i_par_data),
		.i_strobe(i_strobe), .o_rsp_valid(o_rsp_valid), .o_rsp_send(o_rsp_send), .o_rsp_exc(o_rsp_exc),
		.o_rsp_rdata(o_rsp_rdata), .o_rsp_node_addr(o_rsp_node_addr), .o_rsp_baud_div(o_rsp_baud_div),
		.o_node_addr(o_node_addr), .o_baud_div(o_baud_div), .o_reply_delay_chars(o_reply_delay_chars),
		.o_gap_expired(o_gap_expired), .o_luminance(o_luminance), .o_edit_slide(o_edit_slide),
		.o_write_permit(o_write_permit), .o_pattern2(o_pattern2), .o_pattern3(o_pattern3),
		.o_pattern4(o_pattern4));
	mmr_master_model u_mmr_master_model (.i_clk(i_clk), .o_req_valid(i_req_valid), .o_req_write(i_req_write),
		.o_req_broadcast(i_req_broadcast), .o_req_addr(i_req_addr), .o_req_wdata(i_req_wdata));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic op(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d,
		input logic [7:0] e, input logic [15:0] r);
		exp_q.push_back({~b, e, r});
		u_mmr_master_model.xfer(w, b, a, d);
		@(negedge i_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] r);
		op(1'b0, 1'b0, a, 16'h0000, 8'h00, r);
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] e);
		op(1'b1, 1'b0, a, d, e, 16'h0000);
	endtask
	task automatic pulse(input logic [3:0] s, input logic [15:0] d);
		@(posedge i_clk);
		i_par_data <= d;
		i_strobe <= s;
		@(posedge i_clk);
		i_strobe <= 4'h0;
		i_par_data <= ~d;
	endtask
	task automatic end_sim();
		repeat (3) @(negedge i_clk);
		check("pending replies", exp_q.size(), 32'h0);
		$display("tests_run %0d num_errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// reply monitor
	// ----------------------------------------
	always @(negedge i_clk) begin
		if (o_rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("unasked reply", 32'h1, 32'h0);
			end else begin
				check("reply", {o_rsp_send, o_rsp_exc, o_rsp_rdata}, exp_q.pop_front());
			end
		end
	end
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		logic [15:0] a, lo, hi, v, d;
		int n;
		void'($urandom(98050));
		repeat (16) @(posedge i_clk);
		i_reset <= 1'b0;
		foreach (rst_tab[k]) rd(rst_tab[k][31:16], rst_tab[k][15:0]);
		$display("reset values done");
		foreach (rng[k]) begin
			a = rng[k][47:32];
			lo = rng[k][31:16];
			hi = rng[k][15:0];
			v = lo + 16'($urandom % (hi - lo + 16'h1));
			wr(a, hi, 8'h00);
			rd(a, hi);
			wr(a, v, 8'h00);
			wr(a, hi + 16'h1, 8'h03);
			if (lo != 16'h0) wr(a, lo - 16'h1, 8'h03);
			rd(a, v);
		end
		$display("ranges done");
		for (int c = 0; c < 8; c++) begin
			wr(16'h0022, 16'(c), 8'h00);
			check("baud_div", o_baud_div, 32'(100_000_000 / bps[c]));
			check("rsp_baud_div", o_rsp_baud_div, 32'(100_000_000 / bps[c]));
		end
		for (int c = 0; c < 6; c++) begin
			wr(16'h0025, 16'(c), 8'h00);
			check("reply_delay", o_reply_delay_chars, dly[c]);
		end
		wr(16'h002d, 16'h0001, 8'h00);
		check("luminance", o_luminance, 32'h1);
		wr(16'h002f, 16'h0001, 8'h00);
		check("edit_slide", o_edit_slide, 32'h1);
		wr(16'h0013, 16'h00a5, 8'h00);
		check("pattern4", o_pattern4, 32'ha5);
		wr(16'h0011, 16'h005a, 8'h00);
		wr(16'h0012, 16'h003c, 8'h00);
		check("pattern2", o_pattern2, 32'h5a);
		check("pattern3", o_pattern3, 32'h3c);
		wr(16'h0020, 16'h0003, 8'h00);
		wr(16'h0020, 16'h0002, 8'h00);
		check("rsp_node_addr", o_rsp_node_addr, 32'h3);
		check("node_addr", o_node_addr, 32'h2);
		op(1'b1, 1'b1, 16'h002d, 16'h0004, 8'h00, 16'h0000);
		check("luminance", o_luminance, 32'h4);
		wr(16'h0021, 16'h0000, 8'h02);
		wr(16'h0041, 16'h0000, 8'h02);
		op(1'b0, 1'b0, 16'h0024, 16'h0000, 8'h02, 16'h0000);
		$display("settings done");
		d = 16'($urandom);
		pulse(4'h1, d);
		rd(16'h0040, {12'h0, d[3:0]});
		rd(16'h0041, {12'h0, d[7:4]});
		rd(16'h0042, {12'h0, d[11:8]});
		for (int m = 1; m < 4; m++) begin
			for (int k = 0; k < 3; k++) begin
				@(posedge i_clk);
				i_coding_mode <= 2'(m);
				i_strobe_scheme <= 2'h1;
				d = 16'($urandom);
				pulse(4'(1 << k), d);
				rd(16'h0040 + 16'(k), m == 3 ? {9'h0, d[6:0]} : m == 2 ? {8'h0, d[7:0]} : {12'h0, d[3:0]});
			end
		end
		$display("capture done");
		wr(16'h0027, 16'h0001, 8'h00);
		// an expiry left by the earlier random timeout takes two cycles to clear
		repeat (2) @(negedge i_clk);
		n = 2;
		while (o_gap_expired !== 1'b1 && n < 4 * SEC) begin
			@(negedge i_clk);
			n++;
		end
		check("gap time", 32'(n >= SEC - 2 && n <= SEC + 3), 32'h1);
		if (n >= 4 * SEC) end_sim();
		@(posedge i_clk);
		i_frame_rx <= 1'b1;
		@(posedge i_clk);
		i_frame_rx <= 1'b0;
		repeat (3) @(negedge i_clk);
		check("gap cleared", o_gap_expired, 32'h0);
		wr(16'h0027, 16'h0000, 8'h00);
		repeat (3 * SEC) @(negedge i_clk);
		check("gap off", o_gap_expired, 32'h0);
		$display("gap done");
		wr(16'h0023, 16'h0000, 8'h00);
		check("permit", o_write_permit, 32'h0);
		wr(16'h002d, 16'h0002, 8'h08);
		wr(16'h0023, 16'h0001, 8'h08);
		rd(16'h002d, 16'h0004);
		@(posedge i_clk);
		i_reset <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		rd(16'h0023, 16'h0001);
		rd(16'h0022, 16'h0003);
		$display("permit done");
		end_sim();
	end
endmodule
`default_nettype wire

/* test/mmr_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module mmr_chk #(
	parameter int SECOND_CYCLES = 10
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic i_req_broadcast,
	input wire logic [15:0] i_req_addr,
	input wire logic [15:0] i_req_wdata,
	input wire logic i_frame_rx,
	input wire logic o_rsp_valid,
	input wire logic o_rsp_send,
	input wire logic [7:0] o_rsp_exc,
	input wire logic [15:0] o_rsp_rdata,
	input wire logic [7:0] o_rsp_node_addr,
	input wire logic [16:0] o_rsp_baud_div,
	input wire logic [7:0] o_node_addr,
	input wire logic [16:0] o_baud_div,
	input wire logic [7:0] o_reply_delay_chars,
	input wire logic o_gap_expired,
	input wire logic [3:0] o_luminance,
	input wire logic o_write_permit
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// ----------------------------------------
	// quiet time since last frame or accepted timeout write
	// ----------------------------------------
	int unsigned quiet_reg;
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			quiet_reg <= 0;
		end else if (i_frame_rx || (i_req_valid && i_req_write && o_write_permit && i_req_addr == 16'h0027
			&& i_req_wdata <= 16'h0063)) begin
			quiet_reg <= 0;
		end else if (quiet_reg < 32'h00ffffff) begin
			quiet_reg <= quiet_reg + 1;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_send;
		i_req_valid |=> o_rsp_valid && (o_rsp_send == !$past(i_req_broadcast));
	endproperty
	a_send: assert property (p_send) else $error("reply flag wrong");
	property p_old_addr;
		i_req_valid |=> o_rsp_node_addr == $past(o_node_addr);
	endproperty
	a_old_addr: assert property (p_old_addr) else $error("reply address not the old one");
	property p_new_rate;
		i_req_valid |=> o_rsp_baud_div == o_baud_div;
	endproperty
	a_new_rate: assert property (p_new_rate) else $error("reply rate not the current one");
	property p_permit;
		i_req_valid && i_req_write && !o_write_permit |=> o_rsp_exc inside {8'h02, 8'h08};
	endproperty
	a_permit: assert property (p_permit) else $error("write not refused");
	property p_locked;
		!o_write_permit |=> !o_write_permit && $stable(o_luminance) && $stable(o_node_addr);
	endproperty
	a_locked: assert property (p_locked) else $error("setting changed while locked");
	property p_baud;
		o_baud_div inside {17'd83333, 17'd41666, 17'd20833, 17'd10416, 17'd5208, 17'd2604, 17'd1736, 17'd868};
	endproperty
	a_baud: assert property (p_baud) else $error("bad bit divider");
	property p_delay;
		o_reply_delay_chars inside {8'd0, 8'd10, 8'd20, 8'd50, 8'd100, 8'd200};
	endproperty
	a_delay: assert property (p_delay) else $error("bad reply delay");
	property p_lum;
		o_luminance inside {[4'h1:4'h8]};
	endproperty
	a_lum: assert property (p_lum) else $error("luminance out of range");
	property p_node;
		o_node_addr != 8'h00;
	endproperty
	a_node: assert property (p_node) else $error("node address zero");
	property p_sig;
		i_req_valid && !i_req_write && i_req_addr == 16'h0021 |=> o_rsp_rdata == mmr_pkg::SIGNATURE_CODE;
	endproperty
	a_sig: assert property (p_sig) else $error("signature changed");
	property p_gap;
		$rose(o_gap_expired) |-> quiet_reg >= SECOND_CYCLES;
	endproperty
	a_gap: assert property (p_gap) else $error("gap flagged too early");
	c_bcast: cover property (i_req_valid && i_req_broadcast);
	c_gap: cover property ($rose(o_gap_expired));
	c_refuse: cover property (o_rsp_valid && o_rsp_exc == 8'h08);
endmodule
bind mmr_regbank mmr_chk #(.SECOND_CYCLES(SECOND_CYCLES)) u_mmr_chk (.i_clk(i_clk), .i_reset(i_reset),
	.i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_broadcast(i_req_broadcast),
	.i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .i_frame_rx(i_frame_rx), .o_rsp_valid(o_rsp_valid),
	.o_rsp_send(o_rsp_send), .o_rsp_exc(o_rsp_exc), .o_rsp_rdata(o_rsp_rdata),
	.o_rsp_node_addr(o_rsp_node_addr), .o_rsp_baud_div(o_rsp_baud_div), .o_node_addr(o_node_addr),
	.o_baud_div(o_baud_div), .o_reply_delay_chars(o_reply_delay_chars), .o_gap_expired(o_gap_expired),
	.o_luminance(o_luminance), .o_write_permit(o_write_permit));
`default_nettype wire

/* test/mmr_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mmr_master_model (
	input wire logic i_clk,
	output logic o_req_valid,
	output logic o_req_write,
	output logic o_req_broadcast,
	output logic [15:0] o_req_addr,
	output logic [15:0] o_req_wdata
);
	initial begin
		o_req_valid = 1'b0;
		o_req_write = 1'b0;
		o_req_broadcast = 1'b0;
		o_req_addr = 16'h0000;
		o_req_wdata = 16'h0000;
	end
	// one request pulse; the answer is always taken on the next edge
	task automatic xfer(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_req_valid <= 1'b1;
		o_req_write <= w;
		o_req_broadcast <= b;
		o_req_addr <= a;
		o_req_wdata <= d;
		@(posedge i_clk);
		o_req_valid <= 1'b0;
		// released qualifiers show junk, not the last value
		o_req_write <= ~w;
		o_req_broadcast <= ~b;
		o_req_addr <= ~a;
		o_req_wdata <= ~d;
	endtask
endmodule
`default_nettype wire
